// file: hw/mcelog_defines.vh
// Constants for the machine-check error code logger
`ifndef MCELOG_DEFINES_VH
`define MCELOG_DEFINES_VH
`define MCE_A_ID 12'h000
`define MCE_A_CR4 12'h004
`define MCE_A_CAP 12'h008
`define MCE_A_EVT 12'h00C
`define MCE_A_EXC 12'h010
`define MCE_A_CTL0 12'h040
`define MCE_A_STS0 12'h080
`define MCE_A_BANK_STEP 12'h004
`define MCE_A_WIN_MASK 12'hFC0
`define MCE_BANKS 4
`define MCE_BANK_W 2
`define MCE_ID_ARCH_BIT 14
`define MCE_ID_EXC_BIT 7
`define MCE_CR4_EN_BIT 6
`define MCE_CAP_FILT_BIT 11
`define MCE_CAP_CNT_W 8
`define MCE_CODE_F_BIT 12
`define MCE_VECTOR 8'h12
`define MCE_STS_VAL_BIT 31
`define MCE_STS_UC_BIT 30
`define MCE_STS_MS_LSB 16
`define MCE_POST_LIMIT 2'h2
`define MCE_CODE_NONE 16'h0000
`define MCE_CODE_UNCLASS 16'h0001
`define MCE_CODE_UCODE_PAR 16'h0002
`define MCE_CODE_EXT_INIT 16'h0003
`define MCE_CODE_REDUND 16'h0004
`define MCE_CODE_INT_PAR 16'h0005
`define MCE_CODE_SMM_RANGE 16'h0006
`define MCE_CODE_TIMER 16'h0400
`define MCE_CODE_IO 16'h0E0B
`define MCE_SRC_EXT 2'h1
`define MCE_SRC_CODE 2'h0
`endif

// file: hw/mcelog_bank.v
// One error-reporting bank: control word, status word, filter counter
`timescale 1ns/100ps
`default_nettype none
`include "mcelog_defines.vh"
module mcelog_bank (
    input wire hclk,
    input wire hresetn,
    input wire ctl_we,
    input wire sts_we,
    input wire [31:0] wdata,
    input wire err_hit,
    input wire [15:0] err_code,
    input wire [15:0] err_model,
    input wire err_uc,
    output wire [31:0] ctl_q,
    output wire [31:0] sts_q,
    output wire logged
);
    reg [31:0] ctl_r;
    reg [31:0] sts_r;
    reg [1:0] post_cnt_r;
    wire enabled;
    wire filt_ok;
    wire take;
    wire filt_last;

    assign enabled = |(ctl_r & ({31'h0, 1'b1} << err_code[4:0]));
    // Uncorrected events bypass the filter
    assign filt_ok = err_uc | (post_cnt_r < `MCE_POST_LIMIT); // RULE_21
    // Free bank only; a logged word is held until software writes it
    assign take = err_hit & enabled & filt_ok & ~sts_r[`MCE_STS_VAL_BIT]; // RULE_23
    assign filt_last = ~err_uc & (post_cnt_r == (`MCE_POST_LIMIT - 2'h1));
    assign logged = take;
    assign ctl_q = ctl_r;
    assign sts_q = sts_r;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl_r <= 32'h0;
            sts_r <= 32'h0;
            post_cnt_r <= 2'h0;
        end else begin
            if (ctl_we) begin
                ctl_r <= wdata;
            end
            if (take) begin
                // Code, model code, valid flag; bit 12 marks filtering on
                sts_r <= {1'b1, err_uc, err_model[13:0], err_code[15:13],
                    filt_last, err_code[11:0]}; // RULE_08 RULE_09 RULE_19
            end else if (sts_we) begin
                sts_r <= wdata;
            end
            if (take & ~err_uc) begin
                post_cnt_r <= post_cnt_r + 2'h1; // RULE_20
            end else if (sts_we && wdata == 32'h0) begin
                post_cnt_r <= 2'h0;
            end
        end
    end
endmodule // mcelog_bank
`default_nettype wire

// file: hw/mcelog_top.v
// Machine-check error code logger with AHB-Lite register slave
//
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "mcelog_defines.vh"
// How it works
// (RULE_01) Identification word bit 14 shows error reporting, bit 7 the exception.
// (RULE_02) Software clears every bank status to zero after power-up.
// (RULE_03) Software reads bank count from capability count field.
// (RULE_04) Software writes all ones to bank controls; old family 6 skips bank 0.
// (RULE_05) Firmware zeroes status only after power-on reset; OS otherwise.
// (RULE_06) Exception is delivered on vector 18; handler installed first.
// (RULE_07) Exception raised only while control register four bit 6 is set.
// (RULE_08) On error, 16-bit code written to a bank status and valid set.
// (RULE_09) A 16-bit model-specific code may be written alongside; the bank keeps only its low 14 bits, in status bits 29:16.
// (RULE_10) Handler reads code only where the valid flag is set.
// (RULE_11) Error type comes from status bits 15:0 alone, not the bank.
// (RULE_12) All-zero code means no error reported to the bank.
// (RULE_13) Simple codes: unclassified, ROM parity, bus-init, redundancy, parity, range, timer, IO.
// (RULE_14) Internal unclassified is 0000 01 plus ten bits, one at least set.
// (RULE_15) Bus-init raises exception only if strapped on and enable set.
// (RULE_16) Compound forms for generic cache, TLB and cache hierarchy errors.
// (RULE_17) Memory controller and extended memory forms with transaction and channel.
// (RULE_18) Bus and interconnect form with participation, timeout, request, space, level.
// (RULE_19) Code bit 12 set when filtering activated for the line.
// (RULE_20) Capability bit 11 shows filtering; later repeat corrections are dropped.
// (RULE_21) Uncorrected events are always posted.
// (RULE_22) Software ignores the filtering bit for uncorrected errors.
// (RULE_23) Logged status stays until software writes it.
module mcelog_top (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire err_valid,
    input wire [1:0] err_source,
    input wire [3:0] err_class,
    input wire [11:0] err_detail,
    input wire err_filtered_line,
    input wire err_uncorrected,
    input wire [15:0] err_model_code,
    input wire [1:0] err_bank,
    input wire external_bus_init,
    input wire bus_init_strap,
    output wire check_exception,
    output wire [7:0] check_exception_vector
);
    localparam ST_IDLE = 2'b01;
    localparam ST_DATA = 2'b10;

    reg [1:0] state_r;
    reg [11:0] addr_r;
    reg wr_r;
    reg [31:0] rdata_r;
    reg cr4_r;
    reg strap_r;
    reg strap_cap_r;
    reg strap_d1_r;
    reg strap_d2_r;
    reg exc_r;
    reg [15:0] last_code_r;
    reg bi_s1_r;
    reg bi_s2_r;
    reg bi_s3_r;
    reg ev_s1_r;
    reg ev_s2_r;
    reg [15:0] code_nxt;
    reg [31:0] rd_nxt;
    wire [31:0] id_word;
    wire [31:0] cap_word;
    wire bi_rise;
    wire err_any;
    wire [15:0] ev_code;
    wire [1:0] ev_bank;
    wire ev_uc;
    wire [`MCE_BANKS-1:0] bank_logged;
    wire [32*`MCE_BANKS-1:0] ctl_bus;
    wire [32*`MCE_BANKS-1:0] sts_bus;
    wire a_phase;
    wire w_ctl;
    wire w_sts;
    wire [`MCE_BANK_W-1:0] bank_idx;
    wire [11:0] win_base;
    wire exc_set;

    assign a_phase = hsel & hready & htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_r;

    // Identification flags
    assign id_word = ({31'h0, 1'b1} << `MCE_ID_ARCH_BIT) | ({31'h0, 1'b1} << `MCE_ID_EXC_BIT); // RULE_01
    // Count field and filtering support
    assign cap_word = ({31'h0, 1'b1} << `MCE_CAP_FILT_BIT) | `MCE_BANKS; // RULE_20

    // Bus-init pin synchroniser and edge
    assign bi_rise = bi_s2_r & ~bi_s3_r;
    assign err_any = err_valid | bi_rise;
    assign ev_code = code_nxt;
    assign ev_bank = bi_rise ? 2'h0 : err_bank;
    assign ev_uc = bi_rise | err_uncorrected;

    // Error code assembly; type depends on code alone, never on bank
    always @* begin // RULE_11
        code_nxt = `MCE_CODE_NONE; // RULE_12
        if (bi_rise) begin
            code_nxt = `MCE_CODE_EXT_INIT; // RULE_13
        end else if (err_source == `MCE_SRC_CODE) begin
            case (err_class)
                4'h1: code_nxt = `MCE_CODE_UNCLASS; // RULE_13
                4'h2: code_nxt = `MCE_CODE_UCODE_PAR;
                4'h3: code_nxt = `MCE_CODE_REDUND;
                4'h4: code_nxt = `MCE_CODE_INT_PAR;
                4'h5: code_nxt = `MCE_CODE_SMM_RANGE;
                4'h6: code_nxt = `MCE_CODE_TIMER;
                4'h7: code_nxt = `MCE_CODE_IO;
                // Internal unclassified, nonzero low ten bits forced
                4'h8: code_nxt = {6'b000001, (err_detail[9:0] == 10'h0) ? 10'h001 : err_detail[9:0]}; // RULE_14
                // Generic cache hierarchy
                4'h9: code_nxt = {3'b000, err_filtered_line, 10'b0000000011, err_detail[1:0]}; // RULE_16
                // TLB
                4'hA: code_nxt = {3'b000, err_filtered_line, 8'b00000001, err_detail[3:0]}; // RULE_16
                // Cache hierarchy
                4'hB: code_nxt = {3'b000, err_filtered_line, 4'b0001, err_detail[7:0]}; // RULE_16
                // Memory controller
                4'hC: code_nxt = {3'b000, err_filtered_line, 5'b00001, err_detail[6:0]}; // RULE_17
                // Extended memory
                4'hD: code_nxt = {3'b000, err_filtered_line, 5'b00101, err_detail[6:0]}; // RULE_17
                // Bus and interconnect
                4'hE: code_nxt = {3'b000, err_filtered_line, 1'b1, err_detail[10:0]}; // RULE_18
                default: code_nxt = `MCE_CODE_UNCLASS;
            endcase
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `MCE_BANKS; gi = gi + 1) begin : g_bank
            mcelog_bank u_bank (
                .hclk(hclk),
                .hresetn(hresetn),
                .ctl_we(w_ctl && bank_idx == gi),
                .sts_we(w_sts && bank_idx == gi),
                .wdata(hwdata),
                .err_hit(err_any && ev_bank == gi),
                .err_code(ev_code),
                .err_model(err_model_code),
                .err_uc(ev_uc),
                .ctl_q(ctl_bus[32*gi +: 32]),
                .sts_q(sts_bus[32*gi +: 32]),
                .logged(bank_logged[gi])
            );
        end
    endgenerate

    assign win_base = addr_r & `MCE_A_WIN_MASK;
    assign bank_idx = addr_r[`MCE_BANK_W+1:2];
    assign w_ctl = (state_r == ST_DATA) & wr_r & (win_base == `MCE_A_CTL0);
    assign w_sts = (state_r == ST_DATA) & wr_r & (win_base == `MCE_A_STS0);

    // Bus-init needs strap and enable; other logged errors need enable and no bus-init edge in the same cycle
    assign exc_set = cr4_r & ((bi_rise & strap_cap_r) | (|bank_logged & ~bi_rise)); // RULE_07 RULE_15
    assign check_exception = exc_r;
    assign check_exception_vector = `MCE_VECTOR; // RULE_06

    // Read mux
    always @* begin
        rd_nxt = 32'h0;
        if (haddr == `MCE_A_ID) begin
            rd_nxt = id_word;
        end else if (haddr == `MCE_A_CR4) begin
            rd_nxt = {25'h0, cr4_r, 6'h0};
        end else if (haddr == `MCE_A_CAP) begin
            rd_nxt = cap_word;
        end else if (haddr == `MCE_A_EVT) begin
            rd_nxt = {15'h0, strap_cap_r, last_code_r};
        end else if (haddr == `MCE_A_EXC) begin
            rd_nxt = {31'h0, exc_r};
        end else if ((haddr & `MCE_A_WIN_MASK) == `MCE_A_CTL0 && haddr[5:4] == 2'h0) begin
            rd_nxt = ctl_bus[32*haddr[`MCE_BANK_W+1:2] +: 32];
        end else if ((haddr & `MCE_A_WIN_MASK) == `MCE_A_STS0 && haddr[5:4] == 2'h0) begin
            rd_nxt = sts_bus[32*haddr[`MCE_BANK_W+1:2] +: 32];
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= ST_IDLE;
            addr_r <= 12'h0;
            wr_r <= 1'b0;
            rdata_r <= 32'h0;
            cr4_r <= 1'b0;
            strap_r <= 1'b0;
            strap_cap_r <= 1'b0;
            strap_d1_r <= 1'b0;
            strap_d2_r <= 1'b0;
            exc_r <= 1'b0;
            last_code_r <= 16'h0;
            bi_s1_r <= 1'b0;
            bi_s2_r <= 1'b0;
            bi_s3_r <= 1'b0;
            ev_s1_r <= 1'b0;
            ev_s2_r <= 1'b0;
        end else begin
            bi_s1_r <= external_bus_init;
            bi_s2_r <= bi_s1_r;
            bi_s3_r <= bi_s2_r;
            ev_s1_r <= bus_init_strap;
            ev_s2_r <= ev_s1_r;
            // Strap caught once the synchroniser holds the pin level
            strap_d1_r <= 1'b1;
            strap_d2_r <= strap_d1_r;
            strap_r <= strap_d2_r;
            if (!strap_r) begin
                strap_cap_r <= ev_s2_r;
            end
            if (a_phase) begin
                state_r <= ST_DATA;
                addr_r <= haddr;
                wr_r <= hwrite;
                if (!hwrite) begin
                    rdata_r <= rd_nxt;
                end
            end else begin
                state_r <= ST_IDLE;
            end
            if (state_r == ST_DATA && wr_r && addr_r == `MCE_A_CR4) begin
                cr4_r <= hwdata[`MCE_CR4_EN_BIT]; // RULE_07
            end
            if (err_any) begin
                last_code_r <= ev_code;
            end
            // Set wins over software clear
            if (exc_set) begin
                exc_r <= 1'b1;
            end else if (state_r == ST_DATA && wr_r && addr_r == `MCE_A_EXC && hwdata[0]) begin
                exc_r <= 1'b0;
            end
        end
    end
endmodule // mcelog_top
`default_nettype wire

// file: bench/mcelog_asserts.sv
// Concurrent checks on the logger bus and exception ports
`timescale 1ns/100ps
`default_nettype none
module mcelog_asserts (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic check_exception,
    input wire logic [7:0] check_exception_vector
);
    logic [11:0] a_r;
    logic w_r;
    logic en_r;
    wire clr = w_r && a_r == 12'h010 && hwdata[0];
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_r <= 12'h000;
            w_r <= 1'b0;
            en_r <= 1'b0;
        end else begin
            a_r <= haddr;
            w_r <= hsel && hready && htrans[1] && hwrite;
            if (w_r && a_r == 12'h004) en_r <= hwdata[6];
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_rd(logic [11:0] a);
        hsel && hready && htrans[1] && !hwrite && haddr == a;
    endsequence
    sequence s_rd_sts;
        hsel && hready && htrans[1] && !hwrite && haddr[11:4] == 8'h08;
    endsequence
    property p_id; s_rd(12'h000) |=> hrdata[14] && hrdata[7]; endproperty
    a_id: assert property (p_id) else $error("id flags wrong");
    property p_cap; s_rd(12'h008) |=> hrdata[11] && hrdata[7:0] == 8'h04; endproperty
    a_cap: assert property (p_cap) else $error("capability wrong");
    property p_sts; s_rd_sts |=> !hrdata[31] || (hrdata[15:0] != 16'h0000); endproperty
    a_sts: assert property (p_sts) else $error("valid and code disagree");
    property p_unmap; s_rd(12'h100) |=> hrdata == 32'h00000000; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_rise; $rose(check_exception) |-> en_r; endproperty
    a_rise: assert property (p_rise) else $error("exception while disabled");
    property p_fall; $fell(check_exception) |-> $past(clr); endproperty
    a_fall: assert property (p_fall) else $error("exception dropped alone");
    property p_vec; check_exception_vector == 8'h12; endproperty
    a_vec: assert property (p_vec) else $error("vector wrong");
    property p_okay; hreadyout && !hresp; endproperty
    a_okay: assert property (p_okay) else $error("bus response wrong");
endmodule // mcelog_asserts
`default_nettype wire

// file: bench/tb.sv
// Self-checking bench for the error code logger
`timescale 1ns/100ps
`default_nettype none
bind mcelog_top mcelog_asserts i_mcelog_asserts (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .check_exception(check_exception), .check_exception_vector(check_exception_vector));
module tb;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ev = 1'b0, fl = 1'b0, uc = 1'b0;
    logic bini = 1'b0, strap = 1'b1;
    logic [11:0] haddr = 12'h000, det = 12'h000;
    logic [1:0] htrans = 2'h0, src = 2'h0, bank = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [3:0] cls = 4'h0;
    logic [15:0] mdl = 16'h1234;
    logic [31:0] hwdata = 32'h0, q;
    wire [31:0] hrdata;
    wire hreadyout, hresp, cexc;
    wire [7:0] vec;
    int err_total = 0, samples_checked = 0, cyc = 0;
    logic [31:0] tbl [15] = '{32'h10000001, 32'h20000002, 32'h30000004, 32'h40000005, 32'h50000006,
        32'h60000400, 32'h70000E0B, 32'h81550555, 32'h9003000F, 32'hA0060016, 32'hB0150115,
        32'hC02A00AA, 32'hD02A02AA, 32'hE5A30DA3, 32'hF0000001};
    always #25 hclk = ~hclk;
    mcelog_top i_mcelog_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .err_valid(ev), .err_source(src), .err_class(cls),
        .err_detail(det), .err_filtered_line(fl), .err_uncorrected(uc), .err_model_code(mdl), .err_bank(bank),
        .external_bus_init(bini), .bus_init_strap(strap), .check_exception(cexc), .check_exception_vector(vec));
    task end_of_test;
        if (err_total == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task evt(input logic [3:0] c, input logic [11:0] d, input logic f, input logic u, input logic [1:0] b);
        ev <= 1'b1;
        cls <= c;
        det <= d;
        fl <= f;
        uc <= u;
        bank <= b;
        @(posedge hclk);
        ev <= 1'b0;
        repeat (2) @(posedge hclk);
    endtask
    task xchk(input logic e);
        @(negedge hclk);
        chk({31'h0, cexc}, {31'h0, e});
        @(posedge hclk);
    endtask
    task init;
        for (int b = 0; b < 4; b++) begin
            bus(1'b1, 12'h040 + 12'(4 * b), 32'hFFFFFFFF);
            bus(1'b1, 12'h080 + 12'(4 * b), 32'h0);
            rd(12'h080 + 12'(4 * b), 32'h0);
        end
        rd(12'h04C, 32'hFFFFFFFF);
        bus(1'b1, 12'h004, 32'h40);
    endtask
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            end_of_test;
        end
    end
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(12'h000, 32'h00004080);
        rd(12'h008, 32'h00000804);
        bus(1'b1, 12'h100, 32'hFFFFFFFF);
        rd(12'h100, 32'h0);
        init;
        bus(1'b1, 12'h004, 32'h0);
        foreach (tbl[i]) begin
            evt(tbl[i][31:28], tbl[i][27:16], 1'b0, 1'b1, 2'h1);
            rd(12'h084, {2'b11, 14'h1234, tbl[i][15:0]});
            bus(1'b1, 12'h084, 32'h0);
        end
        xchk(1'b0);
        evt(4'h9, 12'h003, 1'b1, 1'b0, 2'h2);
        rd(12'h088, 32'h9234000F);
        evt(4'h1, 12'h000, 1'b0, 1'b1, 2'h2);
        rd(12'h088, 32'h9234000F);
        bus(1'b1, 12'h088, 32'h1);
        evt(4'h9, 12'h003, 1'b1, 1'b0, 2'h2);
        rd(12'h088, 32'h9234100F);
        bus(1'b1, 12'h088, 32'h1);
        evt(4'h9, 12'h003, 1'b1, 1'b0, 2'h2);
        rd(12'h088, 32'h00000001);
        evt(4'h1, 12'h000, 1'b0, 1'b1, 2'h2);
        rd(12'h088, 32'hD2340001);
        bus(1'b1, 12'h004, 32'h40);
        evt(4'h4, 12'h000, 1'b0, 1'b1, 2'h3);
        xchk(1'b1);
        chk({24'h0, vec}, 32'h12);
        bus(1'b1, 12'h010, 32'h1);
        xchk(1'b0);
        bini <= 1'b1;
        repeat (6) @(posedge hclk);
        bini <= 1'b0;
        xchk(1'b1);
        bus(1'b0, 12'h080, 32'h0);
        chk({14'h0, q[31:30], q[15:0]}, {14'h0, 2'b11, 16'h0003});
        hresetn <= 1'b0;
        strap <= 1'b0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        init;
        bini <= 1'b1;
        repeat (6) @(posedge hclk);
        bini <= 1'b0;
        xchk(1'b0);
        end_of_test;
    end
endmodule // tb
`default_nettype wire
